// ### verilog/pixel_gain_color_steering.sv
// Per-colour gain steering, variable gain, black clamp loop and sample edge control.
// Assumes sync and clamp pulses arrive asynchronously; converter words are on the master clock.
`timescale 1ns/1ps
`include "afe_steer_regs.svh"
module pixel_gain_color_steering #(
  parameter int ADC_W = 12,
  parameter int DAC_W = 10,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic SYS_CLK_I,
  input wire logic RST_I,
  input wire logic SER_CLK_I,
  input wire logic SER_DATA_I,
  input wire logic SER_LOAD_I,
  input wire logic VERTICAL_SYNC_I,
  input wire logic HORIZONTAL_SYNC_I,
  input wire logic FIELD_INDICATOR_I,
  input wire logic OPTICAL_BLACK_CLAMP_PULSE_I,
  input wire logic DARK_PIXEL_INPUT_CLAMP_I,
  input wire logic [ADC_W-1:0] ADC_DATA_I,
  input wire logic ADC_VALID_I,
  output logic ADC_READY_O,
  output logic [ADC_W-1:0] PIXEL_DATA_O,
  output logic PIXEL_VALID_O,
  input wire logic PIXEL_READY_I,
  output afe_steer_pkg::gain_index_t GAIN_INDEX_O,
  output afe_steer_pkg::gain_code_t COLOR_GAIN_O,
  output afe_steer_pkg::vga_code_t VGA_GAIN_O,
  output logic [DAC_W-1:0] CLAMP_DAC_O,
  output logic INPUT_CLAMP_O,
  output afe_steer_pkg::edge_pos_t REF_EDGE_POS_O,
  output afe_steer_pkg::edge_pos_t DATA_EDGE_POS_O
);
  import afe_steer_pkg::*;
  localparam int LAT = `HSYNC_LATENCY;
  typedef struct packed {
    logic [2:0] vd_s;
    logic [2:0] hd_s;
    logic [2:0] fld_s;
    logic [2:0] ob_s;
    logic [1:0] dk_s;
    sync_evt_t [LAT-1:0] dly;
    logic [5:0] mode_reg;
    logic [3:0][`GAIN_W-1:0] gains;
    logic [`VGA_W-1:0] vga_reg;
    logic [`CLAMP_W-1:0] clamp_reg;
    logic [5:0] op_reg;
    logic [`EDGE_W-1:0] ref_edge_reg;
    logic [`EDGE_W-1:0] data_edge_reg;
    logic line_sel;
    logic [1:0] pos;
    gain_index_t idx;
    gain_code_t gain;
    logic signed [15:0] acc;
    logic [2:0] line_cnt;
    logic [DAC_W-1:0] corr;
    logic [DAC_W-1:0] dac;
    logic in_clamp;
  } core_t;
  core_t s_reg, s_next;
  reg_write_if wr_if ();
  steer_mode_t mode;
  sync_evt_t ev, cur;
  logic alt_line, clamp_off, ob_end;
  logic [ADC_W+1:0] adc_q, tgt_q;
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Last pattern position of a mode
  function automatic logic [1:0] last_pos(input steer_mode_t m);
    case (m)
      MODE_THREE_ONE, MODE_THREE_TWO: last_pos = 2'h2;
      MODE_FOUR_ONE, MODE_FOUR_TWO: last_pos = 2'h3;
      MODE_OFF: last_pos = 2'h0;
      default: last_pos = 2'h1;
    endcase
  endfunction
  // Gain index for a pattern line and position
  function automatic gain_index_t pattern_index(input steer_mode_t m, input logic ln, input logic [1:0] p);
    case (m)
      MODE_MOSAIC_SEP, MODE_MOSAIC_INTLC: pattern_index = {ln, p[0]};
      MODE_MOSAIC_REP: pattern_index = {1'b0, p[0]} + {1'b0, ln};
      MODE_THREE_TWO: pattern_index = ln ? 2'h2 - p : p;
      MODE_FOUR_TWO: pattern_index = p + {ln, 1'b0};
      MODE_THREE_ONE, MODE_FOUR_ONE: pattern_index = p;
      default: pattern_index = 2'h0;
    endcase
  endfunction
  // Saturating one-step move of the clamp correction
  function automatic logic [DAC_W-1:0] corr_step(input logic [DAC_W-1:0] c, input logic up);
    if (up) begin
      corr_step = (c == '1) ? c : c + DAC_W'(1);
    end else begin
      corr_step = (c == '0) ? c : c - DAC_W'(1);
    end
  endfunction
  // ---------------------------------------------------------------
  // Submodules
  // ---------------------------------------------------------------
  // Serial register writes
  serial_ctl_rx u_rx (
    .clk_i(SYS_CLK_I),
    .rst_i(RST_I),
    .sck_i(SER_CLK_I),
    .sdata_i(SER_DATA_I),
    .sload_i(SER_LOAD_I),
    .wr(wr_if.src)
  );
  // Converter word buffer
  sample_fifo #(.WIDTH(ADC_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_i(SYS_CLK_I),
    .rst_i(RST_I),
    .in_data_i(ADC_DATA_I),
    .in_valid_i(ADC_VALID_I),
    .in_ready_o(ADC_READY_O),
    .out_data_o(PIXEL_DATA_O),
    .out_valid_o(PIXEL_VALID_O),
    .out_ready_i(PIXEL_READY_I)
  );
  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    // Two-stage synchronisers, third stage for edge detection except on the dark clamp input
    s_next.vd_s = {s_reg.vd_s[1:0], VERTICAL_SYNC_I};
    s_next.hd_s = {s_reg.hd_s[1:0], HORIZONTAL_SYNC_I};
    s_next.fld_s = {s_reg.fld_s[1:0], FIELD_INDICATOR_I};
    s_next.ob_s = {s_reg.ob_s[1:0], OPTICAL_BLACK_CLAMP_PULSE_I};
    s_next.dk_s = {s_reg.dk_s[0], DARK_PIXEL_INPUT_CLAMP_I};
    // Register writes
    if (wr_if.valid) begin
      case (wr_if.addr)
        `ADDR_STEER_MODE: s_next.mode_reg = wr_if.data[5:0];
        `ADDR_VGA_GAIN: s_next.vga_reg = wr_if.data[`VGA_W-1:0];
        `ADDR_CLAMP_LEVEL: s_next.clamp_reg = wr_if.data[`CLAMP_W-1:0];
        `ADDR_OPERATION: s_next.op_reg = wr_if.data[5:0];
        `ADDR_REF_EDGE: s_next.ref_edge_reg = wr_if.data[`EDGE_W-1:0];
        `ADDR_DATA_EDGE: s_next.data_edge_reg = wr_if.data[`EDGE_W-1:0];
        default: begin
          if (wr_if.addr[`SER_ADDR_W-1:2] == `ADDR_GAIN_BASE >> 2) begin
            s_next.gains[wr_if.addr[1:0]] = wr_if.data[`GAIN_W-1:0];
          end
        end
      endcase
    end
    // Sync edges, delayed to the horizontal counter reset
    cur.vd = s_reg.vd_s[2] && !s_reg.vd_s[1];
    cur.hd = s_reg.hd_s[2] && !s_reg.hd_s[1];
    cur.fld_fall = s_reg.fld_s[2] && !s_reg.fld_s[1];
    cur.fld_rise = !s_reg.fld_s[2] && s_reg.fld_s[1];
    cur.fld_even = s_reg.fld_s[1];
    s_next.dly = {s_reg.dly[LAT-2:0], cur};
    ev = s_reg.dly[LAT-1];
    mode = steer_mode_t'(s_reg.mode_reg[`MODE_LSB +: `MODE_W]);
    alt_line = (mode == MODE_MOSAIC_SEP) || (mode == MODE_MOSAIC_REP) || (mode == MODE_THREE_TWO)
      || (mode == MODE_FOUR_TWO);
    // Steering position advance
    s_next.pos = (s_reg.pos >= last_pos(mode)) ? 2'h0 : s_reg.pos + 2'h1;
    if (mode == MODE_MOSAIC_INTLC) begin
      if (ev.fld_fall) begin
        s_next.line_sel = 1'b0;
        s_next.pos = 2'h0;
      end else if (ev.fld_rise) begin
        s_next.line_sel = 1'b1;
        s_next.pos = 2'h0;
      end else if (ev.hd) begin
        s_next.line_sel = ev.fld_even;
        s_next.pos = 2'h0;
      end
    end else if (ev.vd) begin
      s_next.line_sel = 1'b0;
      s_next.pos = 2'h0;
    end else if (ev.hd) begin
      s_next.line_sel = alt_line ? !s_reg.line_sel : 1'b0;
      s_next.pos = 2'h0;
    end
    s_next.idx = pattern_index(mode, s_next.line_sel, s_next.pos);
    s_next.gain = s_next.gains[s_next.idx];
    // Optical black clamp loop
    clamp_off = s_reg.op_reg[`OP_CLAMP_OFF_BIT];
    adc_q = {ADC_DATA_I, 2'h0};
    tgt_q = (ADC_W == `ADC_W_NARROW) ? (ADC_W+2)'(s_reg.clamp_reg)
      : (ADC_W+2)'({s_reg.clamp_reg, 2'h0});
    ob_end = s_reg.ob_s[2] && !s_reg.ob_s[1];
    if (clamp_off) begin
      s_next.acc = 16'sh0000;
      s_next.line_cnt = 3'h0;
    end else if (ob_end) begin
      s_next.acc = 16'sh0000;
      if (s_reg.line_cnt == 3'((4'h1 << s_reg.op_reg[`OP_RATE_LSB +: `OP_RATE_W]) - 4'h1)) begin
        s_next.line_cnt = 3'h0;
        if (s_reg.acc != 16'sh0000) begin
          // Words mostly below target raise the correction, so the loop closes
          s_next.corr = corr_step(s_reg.corr, s_reg.acc > 16'sh0000);
        end
      end else begin
        s_next.line_cnt = s_reg.line_cnt + 3'h1;
      end
    end else if (s_reg.ob_s[1] && ADC_VALID_I) begin
      if (adc_q > tgt_q) begin
        s_next.acc = s_reg.acc - 16'sh0001;
      end else if (adc_q < tgt_q) begin
        s_next.acc = s_reg.acc + 16'sh0001;
      end
    end
    s_next.dac = clamp_off ? DAC_W'(s_next.clamp_reg) : s_next.corr;
    s_next.in_clamp = s_reg.dk_s[1];
  end
  // State register
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      // Vertical and horizontal sync stages start at the idle high level so no edge follows reset; field and clamp stages start low
      s_reg <= '{vd_s: 3'h7, hd_s: 3'h7, fld_s: 3'h0, ob_s: 3'h0, dk_s: 2'h0, dly: '0,
        mode_reg: `RESET_MODE, gains: '0, vga_reg: `RESET_VGA, clamp_reg: `RESET_CLAMP,
        op_reg: `RESET_OP, ref_edge_reg: `RESET_EDGE, data_edge_reg: `RESET_EDGE,
        line_sel: 1'b0, pos: 2'h0, idx: 2'h0, gain: '0, acc: 16'sh0000, line_cnt: 3'h0,
        corr: '0, dac: '0, in_clamp: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end
  // Outputs
  assign GAIN_INDEX_O = s_reg.idx;
  assign COLOR_GAIN_O = s_reg.gain;
  assign VGA_GAIN_O = s_reg.vga_reg;
  assign CLAMP_DAC_O = s_reg.dac;
  assign INPUT_CLAMP_O = s_reg.in_clamp;
  assign REF_EDGE_POS_O = s_reg.ref_edge_reg;
  assign DATA_EDGE_POS_O = s_reg.data_edge_reg;
  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (RST_I);
  sequence s_hd_fall;
    s_reg.hd_s[2] && !s_reg.hd_s[1];
  endsequence
  sequence s_hd_event;
    s_reg.dly[LAT-1].hd;
  endsequence
  a_hd_latency_eight: assert property (s_hd_fall |-> ##8 s_hd_event)
    else $error("horizontal event not delayed by eight clocks");
  a_vd_restart_first: assert property (ev.vd && mode != MODE_MOSAIC_INTLC |=>
    s_reg.line_sel == 1'b0 && s_reg.pos == 2'h0) else $error("vertical sync did not restart line");
  a_hd_alternate_line: assert property (ev.hd && !ev.vd && alt_line |=>
    s_reg.line_sel != $past(s_reg.line_sel)) else $error("horizontal sync did not alternate line");
  a_fld_even_start: assert property (mode == MODE_MOSAIC_INTLC && ev.fld_rise |=>
    GAIN_INDEX_O == 2'h2) else $error("even field did not start on index two");
  a_hd_intlc_base: assert property (mode == MODE_MOSAIC_INTLC && ev.hd && !ev.fld_fall && !ev.fld_rise
    |=> GAIN_INDEX_O == ($past(ev.fld_even) ? 2'h2 : 2'h0))
    else $error("interlaced line start index wrong");
  a_single_line_zero: assert property ((mode == MODE_THREE_ONE || mode == MODE_FOUR_ONE)
    && (ev.vd || ev.hd) |=> GAIN_INDEX_O == 2'h0 ##1 GAIN_INDEX_O == 2'h1)
    else $error("single line pattern did not restart at zero");
  a_pos_advance: assert property (!ev.vd && !ev.hd && !ev.fld_fall && !ev.fld_rise && s_reg.pos != 2'h0
    && $stable(mode) |-> $past(s_reg.pos) == s_reg.pos - 2'h1)
    else $error("steering position skipped");
  a_gain_matches_idx: assert property (COLOR_GAIN_O == s_reg.gains[GAIN_INDEX_O])
    else $error("gain code does not match index");
  a_clamp_off_offset: assert property (clamp_off && $stable(s_reg.clamp_reg) |=>
    CLAMP_DAC_O == DAC_W'(s_reg.clamp_reg)) else $error("disabled loop does not present offset");
  a_corr_line_only: assert property (!ob_end |=> $stable(s_reg.corr))
    else $error("clamp correction moved outside line update");
  a_edge_reg_write: assert property (wr_if.valid && wr_if.addr == `ADDR_REF_EDGE |=>
    REF_EDGE_POS_O == $past(wr_if.data[`EDGE_W-1:0])) else $error("reference edge not stored");
  a_data_edge_write: assert property (wr_if.valid && wr_if.addr == `ADDR_DATA_EDGE |=>
    DATA_EDGE_POS_O == $past(wr_if.data[`EDGE_W-1:0])) else $error("data edge not stored");
  a_vga_reg_write: assert property (wr_if.valid && wr_if.addr == `ADDR_VGA_GAIN |=>
    VGA_GAIN_O == $past(wr_if.data[`VGA_W-1:0])) else $error("variable gain code not stored");
  a_gain_reg_write: assert property (wr_if.valid && wr_if.addr[`SER_ADDR_W-1:2] == (`ADDR_GAIN_BASE >> 2) |=>
    s_reg.gains[$past(wr_if.addr[1:0])] == $past(wr_if.data[`GAIN_W-1:0])) else $error("colour gain not stored");
  // Second-line patterns, first two positions
  sequence s_rep_line_two;
    GAIN_INDEX_O == 2'h1 ##1 GAIN_INDEX_O == 2'h2;
  endsequence
  sequence s_four_line_two;
    GAIN_INDEX_O == 2'h2 ##1 GAIN_INDEX_O == 2'h3;
  endsequence
  a_rep_second_line: assert property (mode == MODE_MOSAIC_REP && ev.hd && !ev.vd && !s_reg.line_sel |=>
    s_rep_line_two) else $error("repeat mosaic second line not on one two");
  a_four_second_line: assert property (mode == MODE_FOUR_TWO && ev.hd && !ev.vd && !s_reg.line_sel |=>
    s_four_line_two) else $error("four colour second line not on two three");
endmodule

// ### verilog/afe_steer_regs.svh
// Register offsets, field positions and timing counts of the colour steering block.
// Assumes one 12-bit address and one 12-bit data word per serial write frame.
`ifndef AFE_STEER_REGS_SVH
`define AFE_STEER_REGS_SVH
// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define ADDR_OPERATION 12'h000
`define ADDR_VGA_GAIN 12'h004
`define ADDR_CLAMP_LEVEL 12'h005
`define ADDR_STEER_MODE 12'h006
`define ADDR_GAIN_BASE 12'h008
`define ADDR_REF_EDGE 12'h0E9
`define ADDR_DATA_EDGE 12'h0EA
// ---------------------------------------------------------------
// Field layout and widths
// ---------------------------------------------------------------
`define SER_ADDR_W 12
`define SER_DATA_W 12
`define SER_FRAME_BITS 5'h18
`define MODE_LSB 0
`define MODE_W 3
`define OP_CLAMP_OFF_BIT 5
`define OP_RATE_LSB 0
`define OP_RATE_W 2
`define GAIN_W 6
`define EDGE_W 6
`define VGA_W 10
`define CLAMP_W 8
`define ADC_W_NARROW 10
`define CLAMP_FRAC 2
// ---------------------------------------------------------------
// Reset values and timing
// ---------------------------------------------------------------
`define RESET_MODE 6'h00
`define RESET_EDGE 6'h00
`define RESET_VGA 10'h000
`define RESET_CLAMP 8'h00
`define RESET_OP 6'h00
`define HSYNC_LATENCY 8
`endif

// ### verilog/afe_steer_pkg.sv
// Types shared by the colour steering block and its helpers.
// Assumes afe_steer_regs.svh is compiled alongside.
package afe_steer_pkg;
  typedef logic [5:0] gain_code_t;
  typedef logic [1:0] gain_index_t;
  typedef logic [9:0] vga_code_t;
  typedef logic [5:0] edge_pos_t;
  // Sync events as seen after the horizontal counter latency
  typedef struct packed {
    logic vd;
    logic hd;
    logic fld_fall;
    logic fld_rise;
    logic fld_even;
  } sync_evt_t;
  typedef enum logic [2:0] {
    MODE_MOSAIC_SEP, MODE_MOSAIC_INTLC, MODE_MOSAIC_REP, MODE_THREE_ONE,
    MODE_THREE_TWO, MODE_FOUR_ONE, MODE_FOUR_TWO, MODE_OFF
  } steer_mode_t;
  typedef enum logic {SER_IDLE, SER_SHIFT} ser_state_t;
endpackage

// ### verilog/reg_write_if.sv
// Register write strobe from the serial port to the steering core.
// Assumes both ends run on the master clock.
`timescale 1ns/1ps
`include "afe_steer_regs.svh"
interface reg_write_if;
  logic valid;
  logic [`SER_ADDR_W-1:0] addr;
  logic [`SER_DATA_W-1:0] data;
  modport src(output valid, output addr, output data);
  modport dst(input valid, input addr, input data);
endinterface

// ### verilog/serial_ctl_rx.sv
// Three-wire serial write port: address then data, MSB first.
// Assumes serial pins are asynchronous to the master clock.
`timescale 1ns/1ps
`include "afe_steer_regs.svh"
module serial_ctl_rx (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sck_i,
  input wire logic sdata_i,
  input wire logic sload_i,
  reg_write_if.src wr
);
  import afe_steer_pkg::*;
  typedef struct packed {
    logic [2:0] sck_s;
    logic [1:0] sd_s;
    logic [2:0] sl_s;
    ser_state_t state;
    logic [4:0] cnt;
    logic [`SER_ADDR_W+`SER_DATA_W-1:0] shreg;
    logic valid;
  } rx_t;
  rx_t s_reg, s_next;
  // ---------------------------------------------------------------
  // Frame decoder
  // ---------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.sck_s = {s_reg.sck_s[1:0], sck_i};
    s_next.sd_s = {s_reg.sd_s[0], sdata_i};
    s_next.sl_s = {s_reg.sl_s[1:0], sload_i};
    s_next.valid = 1'b0;
    case (s_reg.state)
      SER_IDLE: begin
        s_next.cnt = 5'h00;
        if (!s_reg.sl_s[1]) begin
          s_next.state = SER_SHIFT;
        end
      end
      SER_SHIFT: begin
        if (s_reg.sck_s[1] && !s_reg.sck_s[2]) begin
          s_next.shreg = {s_reg.shreg[`SER_ADDR_W+`SER_DATA_W-2:0], s_reg.sd_s[1]};
          // Saturate past the frame length so that a long frame never looks complete
          if (s_reg.cnt != '1) begin
            s_next.cnt = s_reg.cnt + 5'h01;
          end
        end
        if (s_reg.sl_s[1]) begin
          s_next.valid = (s_reg.cnt == `SER_FRAME_BITS); // Short or long frames are dropped
          s_next.state = SER_IDLE;
        end
      end
      default: s_next.state = SER_IDLE;
    endcase
  end
  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg <= '{sck_s: 3'h0, sd_s: 2'h0, sl_s: 3'h7, state: SER_IDLE, cnt: 5'h00, shreg: '0, valid: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end
  assign wr.valid = s_reg.valid;
  assign wr.addr = s_reg.shreg[`SER_ADDR_W+`SER_DATA_W-1:`SER_DATA_W];
  assign wr.data = s_reg.shreg[`SER_DATA_W-1:0];
endmodule

// ### verilog/sample_fifo.sv
// Converter word FIFO with a registered output stage.
// Assumes producer and consumer share the master clock.
`timescale 1ns/1ps
module sample_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic in_rdy;
    logic ov;
    logic [WIDTH-1:0] od;
  } fifo_t;
  fifo_t s_reg, s_next;
  logic push, pop;
  // Pointer advance with wrap at DEPTH
  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction
  // ---------------------------------------------------------------
  // Storage and output stage
  // ---------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    push = in_valid_i && s_reg.in_rdy;
    pop = (s_reg.cnt != '0) && (!s_reg.ov || out_ready_i);
    if (s_reg.ov && out_ready_i) begin
      s_next.ov = 1'b0;
    end
    if (pop) begin
      s_next.od = s_reg.mem[s_reg.rp];
      s_next.ov = 1'b1;
      s_next.rp = bump(s_reg.rp);
    end
    if (push) begin
      s_next.mem[s_reg.wp] = in_data_i;
      s_next.wp = bump(s_reg.wp);
    end
    s_next.cnt = s_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
    s_next.in_rdy = (s_next.cnt != (AW+1)'(DEPTH)); // Full stalls the source
  end
  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg <= '{mem: '0, wp: '0, rp: '0, cnt: '0, in_rdy: 1'b1, ov: 1'b0, od: '0};
    end else begin
      s_reg <= s_next;
    end
  end
  assign in_ready_o = s_reg.in_rdy;
  assign out_data_o = s_reg.od;
  assign out_valid_o = s_reg.ov;
  a_fifo_count_bound: assert property (@(posedge clk_i) disable iff (rst_i)
    s_reg.cnt <= (AW+1)'(DEPTH)) else $error("fifo count above depth");
endmodule

// ### tb/sensor_model.sv
// Far-side model: sensor word source with random stalls and the black clamp pulses.
// Assumes the bench reads the queue of accepted words to predict the block's output.
`timescale 1ns/1ps
module sensor_model #(
  parameter int ADC_W = 12
) (
  input wire logic clk_i,
  input wire logic ready_i,
  output logic [ADC_W-1:0] data_o,
  output logic valid_o,
  output logic ob_o,
  output logic dark_o
);
  logic run;
  logic dark_words;
  logic [ADC_W-1:0] sent[$];
  // Idle levels at time zero
  initial begin
    run = 1'b0; // Held off until the bench lifts reset
    dark_words = 1'b0;
    data_o = '0;
    valid_o = 1'b0;
    ob_o = 1'b0;
    dark_o = 1'b0;
  end
  // Offer words with random gaps; an offered word holds until it is taken
  always @(posedge clk_i) begin
    if (valid_o && ready_i) begin
      sent.push_back(data_o);
    end
    if (!valid_o || ready_i) begin
      valid_o <= #1 run && ($urandom_range(3) != 0);
      data_o <= #1 dark_words ? '0 : ADC_W'($urandom);
    end
  end
  // Shielded interval of one line: black words, clamp pulse 24 pixels, dark pulse 4 inside it
  task automatic black_line();
    @(posedge clk_i);
    dark_words = 1'b1;
    ob_o <= #1 1'b1;
    dark_o <= #1 1'b1;
    repeat (4) @(posedge clk_i);
    dark_o <= #1 1'b0;
    repeat (20) @(posedge clk_i);
    ob_o <= #1 1'b0;
    repeat (6) @(posedge clk_i);
    dark_words = 1'b0;
  endtask
endmodule

// ### tb/test_pixel_gain_color_steering.sv
// Self-checking bench of the colour steering block: registers, steering modes, clamp, FIFO.
// Assumes the sensor model stands on the converter side; serial frames are write only.
`timescale 1ns/1ps
`include "afe_steer_regs.svh"
module test_pixel_gain_color_steering;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sck = 1'b0;
  logic sdat = 1'b0;
  logic sload = 1'b1;
  logic vd = 1'b1;
  logic hd = 1'b1;
  logic field_indicator = 1'b0;
  logic pix_ready = 1'b0;
  logic rand_rdy = 1'b0;
  logic ob, dark, adc_valid, adc_ready, pix_valid, in_clamp;
  logic [11:0] adc_data, pix_data;
  logic [1:0] gidx;
  logic [5:0] gcode, ref_pos, data_pos;
  logic [9:0] vga, dac, c0;
  logic [5:0] gains[4];
  int fails = 0;
  int total_checks = 0;
  int clamp_cnt = 0;
  int ex;
  string lp;
  // Pixel clock, 100 MHz
  always #5 clk = ~clk;
  sensor_model #(.ADC_W(12)) u_sensor (.clk_i(clk), .ready_i(adc_ready), .data_o(adc_data),
    .valid_o(adc_valid), .ob_o(ob), .dark_o(dark));
  pixel_gain_color_steering #(.ADC_W(12), .DAC_W(10), .FIFO_DEPTH(8)) u_dut (
    .SYS_CLK_I(clk), .RST_I(rst), .SER_CLK_I(sck), .SER_DATA_I(sdat), .SER_LOAD_I(sload),
    .VERTICAL_SYNC_I(vd), .HORIZONTAL_SYNC_I(hd), .FIELD_INDICATOR_I(field_indicator),
    .OPTICAL_BLACK_CLAMP_PULSE_I(ob), .DARK_PIXEL_INPUT_CLAMP_I(dark), .ADC_DATA_I(adc_data),
    .ADC_VALID_I(adc_valid), .ADC_READY_O(adc_ready), .PIXEL_DATA_O(pix_data),
    .PIXEL_VALID_O(pix_valid), .PIXEL_READY_I(pix_ready), .GAIN_INDEX_O(gidx),
    .COLOR_GAIN_O(gcode), .VGA_GAIN_O(vga), .CLAMP_DAC_O(dac), .INPUT_CLAMP_O(in_clamp),
    .REF_EDGE_POS_O(ref_pos), .DATA_EDGE_POS_O(data_pos));
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Step whole cycles, landing just after the rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
    if (rand_rdy) pix_ready = 1'($urandom);
  endtask
  // One write frame: 12 address bits then 12 data bits, MSB first
  task automatic ser_write(input logic [11:0] addr, input logic [11:0] data);
    logic [23:0] frame;
    frame = {addr, data};
    sload = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      sdat = frame[i];
      tick(4);
      sck = 1'b1;
      tick(4);
      sck = 1'b0;
    end
    tick(4);
    sload = 1'b1;
    tick(8);
  endtask
  // Period of the line pattern expected for a mode, line number and field level
  function automatic string pat(input int mode, input int line, input logic f);
    case (mode)
      0: return (line % 2) ? "23" : "01";
      1: return f ? "23" : "01";
      2: return (line % 2) ? "12" : "01";
      3: return "012";
      4: return (line % 2) ? "210" : "012";
      5: return "0123";
      6: return (line % 2) ? "2301" : "0123";
      default: return "0";
    endcase
  endfunction
  // Words leaving the FIFO must match accepted words in order
  always @(posedge clk) begin
    if (pix_valid === 1'b1 && pix_ready === 1'b1) begin
      check(pix_data, u_sensor.sent.size() ? u_sensor.sent.pop_front() : 12'hFFF);
    end
    if (in_clamp === 1'b1) clamp_cnt++;
  end
  // Watchdog over the whole run
  initial begin
    repeat (50000) @(posedge clk);
    fails++;
    final_report();
  end
  // Main sequence
  initial begin
    void'($urandom(4));
    tick(3);
    check(12'(vga), 12'h000);
    check(12'(ref_pos), 12'h000);
    check({1'b0, adc_ready, dac}, 12'h400);
    rst = 1'b0;
    // Words flow only once the block is out of reset
    u_sensor.run = 1'b1;
    tick(2);
    for (int k = 0; k < 4; k++) begin
      gains[k] = (k == 3) ? 6'h3F : 6'($urandom);
      ser_write(`ADDR_GAIN_BASE + 12'(k), 12'(gains[k]));
    end
    ser_write(`ADDR_REF_EDGE, 12'h02A);
    ser_write(`ADDR_DATA_EDGE, 12'h015);
    ser_write(12'h0EB, 12'h03F);
    check({ref_pos, data_pos}, 12'hA95);
    ser_write(`ADDR_VGA_GAIN, 12'h3FF);
    check(12'(vga), 12'h3FF);
    c0 = 10'($urandom_range(1022));
    ser_write(`ADDR_VGA_GAIN, 12'(c0));
    check(12'(vga), 12'(c0));
    rand_rdy = 1'b1;
    for (int m = 0; m < 8; m++) begin
      ser_write(`ADDR_STEER_MODE, 12'(m));
      for (int ln = 0; ln < 4; ln++) begin
        // Interlaced mode gets both field edges; other modes a random field level
        field_indicator = (m == 1) ? 1'(ln) : 1'($urandom);
        tick(6);
        hd = 1'b0;
        vd = (ln != 0);
        tick(4);
        hd = 1'b1;
        vd = 1'b1;
        tick(14);
        lp = pat(m, ln, field_indicator);
        // Line start shows 2 sync + 8 latency + 1 output cycles after the pin; 18 have passed
        for (int j = 0; j < 8; j++) begin
          ex = lp[(7 + j) % lp.len()] - 8'h30;
          check(12'(gidx), 12'(ex));
          check(12'(gcode), 12'(gains[ex]));
          tick(1);
        end
      end
    end
    rand_rdy = 1'b0;
    pix_ready = 1'b1;
    ser_write(`ADDR_CLAMP_LEVEL, 12'h0C5);
    ser_write(`ADDR_OPERATION, 12'h020);
    check(12'(dac), 12'h0C5);
    // Rate 1 updates on every second line, rate 0 on every line
    ser_write(`ADDR_OPERATION, 12'h001);
    for (int n = 0; n < 4; n++) begin
      if (n == 2) begin
        ser_write(`ADDR_OPERATION, 12'h000);
      end
      c0 = dac;
      clamp_cnt = 0;
      u_sensor.black_line();
      tick(8);
      check(12'(dac), 12'(c0) + 12'(n != 0));
      check(12'(clamp_cnt), 12'h004);
    end
    pix_ready = 1'b0;
    tick(40);
    check(12'(adc_ready), 12'h000);
    u_sensor.run = 1'b0;
    pix_ready = 1'b1;
    tick(30);
    check(12'(u_sensor.sent.size()), 12'h000);
    check(12'(pix_valid), 12'h000);
    // Reset again in mid-run: registers return to their reset values
    rst = 1'b1;
    tick(3);
    rst = 1'b0;
    tick(2);
    check(12'(vga), 12'h000);
    check({ref_pos, data_pos}, 12'h000);
    check(12'(dac), 12'h000);
    check(12'(gcode), 12'h000);
    final_report();
  end
endmodule
